// ===== core/rtc_count_hold_and_pulse_out.sv
// RTC seconds/minutes counter with count hold and one-second pulse output
module rtc_count_hold_and_pulse_out (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rtc_hold_pkg::axi_req_s axi_req,
    output rtc_hold_pkg::axi_rsp_s axi_rsp,
    input wire logic rtc_src_clk,
    output logic second_pulse_pin
);
    import rtc_hold_pkg::*;

    // Byte-lane merge used by the control and compare registers
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Address decode shared by the read and write paths
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a inside {OFF_CONTROL_ONE, OFF_CONTROL_TWO, OFF_STATUS,
                         OFF_COMPARE, OFF_TICK_LOW, OFF_TICK_HIGH,
                         OFF_SECONDS, OFF_MINUTES};
    endfunction

    logic aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_go;
    logic wr_ok;

    logic hold_req_q;
    logic run_q;
    logic [SEL_W-1:0] sel_q;
    logic pulse_en_q;
    logic [CNT_W-1:0] compare_q;
    logic hold_ack_q;
    logic pending_q;
    logic [5:0] seconds_q;
    logic [5:0] minutes_q;
    logic [CNT_W-1:0] tick_q;
    logic run_prev_q;
    logic [5:0] pre_q;
    logic src_meta_q;
    logic src_sync_q;
    logic src_prev_q;
    logic src_edge;
    logic pre_tick;
    logic cnt_tick;
    logic second_evt;
    logic advance;
    logic sw_sec_wr;
    logic sw_min_wr;
    logic [31:0] ctl_one_d;
    logic [31:0] ctl_two_d;
    logic [31:0] compare_d;

    // Write channels are taken independently; both must be held to act
    assign axi_rsp.awready = !aw_held_q && !bvalid_q;
    assign axi_rsp.wready = !w_held_q && !bvalid_q;
    assign axi_rsp.bvalid = bvalid_q;
    assign axi_rsp.bresp = bresp_q;
    assign axi_rsp.arready = !rvalid_q;
    assign axi_rsp.rvalid = rvalid_q;
    assign axi_rsp.rdata = rdata_q;
    assign axi_rsp.rresp = rresp_q;
    assign wr_go = aw_held_q && w_held_q && !bvalid_q;
    assign wr_ok = wr_go && is_mapped(aw_addr_q);

    // Latch write address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (axi_req.awvalid && axi_rsp.awready)
        begin
            aw_held_q <= 1'b1;
            aw_addr_q <= axi_req.awaddr;
        end
        else if (wr_go)
        begin
            aw_held_q <= 1'b0;
        end
    end

    // Latch write data and strobes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else if (axi_req.wvalid && axi_rsp.wready)
        begin
            w_held_q <= 1'b1;
            w_data_q <= axi_req.wdata;
            w_strb_q <= axi_req.wstrb;
        end
        else if (wr_go)
        begin
            w_held_q <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (axi_req.bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Read path; reserved bits read zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else if (axi_req.arvalid && axi_rsp.arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (axi_req.araddr)
                OFF_CONTROL_ONE: rdata_q <= 32'({sel_q, run_q, hold_req_q});
                OFF_CONTROL_TWO: rdata_q <= 32'(pulse_en_q);
                OFF_STATUS: rdata_q <= 32'(hold_ack_q);
                OFF_COMPARE: rdata_q <= 32'(compare_q);
                OFF_TICK_LOW: rdata_q <= 32'(tick_q[7:0]);
                OFF_TICK_HIGH: rdata_q <= 32'(tick_q[CNT_W-1:8]);
                OFF_SECONDS: rdata_q <= 32'(seconds_q);
                OFF_MINUTES: rdata_q <= 32'(minutes_q);
                default: rdata_q <= '0;
            endcase
        end
        else if (axi_req.rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign ctl_one_d = merge_bytes(32'({sel_q, run_q, hold_req_q}),
                                   w_data_q, w_strb_q);
    assign ctl_two_d = merge_bytes(32'(pulse_en_q), w_data_q, w_strb_q);
    assign compare_d = merge_bytes(32'(compare_q), w_data_q, w_strb_q);

    // Control registers written by software
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hold_req_q <= 1'b0;
            run_q <= 1'b0;
            sel_q <= RST_SEL;
            pulse_en_q <= 1'b0;
            compare_q <= RST_COMPARE;
        end
        else if (wr_ok)
        begin
            unique case (aw_addr_q)
                OFF_CONTROL_ONE:
                begin
                    hold_req_q <= ctl_one_d[BIT_HOLD_REQ];
                    run_q <= ctl_one_d[BIT_RUN];
                    sel_q <= ctl_one_d[POS_SEL +: SEL_W];
                end
                OFF_CONTROL_TWO: pulse_en_q <= ctl_two_d[BIT_PULSE_EN];
                OFF_COMPARE: compare_q <= compare_d[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Source clock pin passes two flops before edge detection
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_meta_q <= 1'b0;
            src_sync_q <= 1'b0;
            src_prev_q <= 1'b0;
        end
        else
        begin
            src_meta_q <= rtc_src_clk;
            src_sync_q <= src_meta_q;
            src_prev_q <= src_sync_q;
        end
    end

    assign src_edge = src_sync_q && !src_prev_q;
    // Prescale divides source edges by two to the power of the select, capped at 64 for selects 6 and 7
    assign pre_tick = src_edge && (pre_q == 6'((7'h01 << sel_q) - 7'h01));
    assign cnt_tick = run_q && pre_tick;

    // Prescaler restarts on every run start
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run_q)
        begin
            pre_q <= '0;
        end
        else if (pre_tick)
        begin
            pre_q <= '0;
        end
        else if (src_edge)
        begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // Tick counter reloads to one after matching compare, so period = compare
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_prev_q <= 1'b0;
            tick_q <= '0;
        end
        else
        begin
            run_prev_q <= run_q;
            if (run_q && !run_prev_q)
            begin
                tick_q <= '0;
            end
            else if (cnt_tick)
            begin
                tick_q <= (tick_q == compare_q) ? 20'h00001 :
                          tick_q + 20'h00001;
            end
        end
    end

    // One event per compare match, one cycle wide
    assign second_evt = cnt_tick && (tick_q == compare_q);

    // Pulse pin falls on full match, rises on half match, high when idle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            second_pulse_pin <= 1'b1;
        end
        else if (!run_q || !run_prev_q || !pulse_en_q)
        begin
            // First run cycle still holds the stale count, so stay high
            second_pulse_pin <= 1'b1;
        end
        else if (tick_q == compare_q)
        begin
            second_pulse_pin <= 1'b0;
        end
        else if (tick_q == (compare_q >> 1))
        begin
            second_pulse_pin <= 1'b1;
        end
    end

    // Acknowledge follows request one cycle later, rising and dropping
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hold_ack_q <= 1'b0;
        end
        else
        begin
            hold_ack_q <= hold_req_q;
        end
    end

    // A single flag, so extra missed seconds collapse into one
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pending_q <= 1'b0;
        end
        else if (hold_ack_q && second_evt)
        begin
            pending_q <= 1'b1;
        end
        else if (!hold_ack_q)
        begin
            pending_q <= 1'b0;
        end
    end

    // Advance is blocked as soon as the request is seen, before the ack
    assign advance = !hold_req_q && !hold_ack_q ? second_evt :
                     (!hold_req_q && (pending_q || second_evt));
    assign sw_sec_wr = wr_ok && (aw_addr_q == OFF_SECONDS) && w_strb_q[0];
    assign sw_min_wr = wr_ok && (aw_addr_q == OFF_MINUTES) && w_strb_q[0];

    // Seconds and minutes; a software write wins over a same-cycle advance
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seconds_q <= '0;
        end
        else if (sw_sec_wr)
        begin
            seconds_q <= w_data_q[5:0];
        end
        else if (advance)
        begin
            seconds_q <= (seconds_q == LAST_UNIT) ? 6'h00 : seconds_q + 6'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            minutes_q <= '0;
        end
        else if (sw_min_wr)
        begin
            minutes_q <= w_data_q[5:0];
        end
        else if (advance && seconds_q == LAST_UNIT)
        begin
            minutes_q <= (minutes_q == LAST_UNIT) ? 6'h00 : minutes_q + 6'h01;
        end
    end

endmodule

// ===== core/rtc_hold_pkg.sv
// Constants, register map and bus carriers of the RTC hold and pulse block
// Behaviour
// - Software can freeze once-per-second counter advance
// - Hold request stops advance, then acknowledge reads one
// - Tick during hold applied once hold released; one in the cycle before acknowledge is lost
// - At most one pending second kept
// - Tick counter read as low byte, high/middle
// - Roughly 1 Hz square wave on pulse pin
// - Stopped clock with output enabled holds pin high
// - Pin falls when counter equals compare value
// - Pin rises at half compare; odd shortens low
// - Phase length scales with compare, source, prescale
package rtc_hold_pkg;

    localparam int ADDR_W = 8;
    localparam int CNT_W = 20;
    localparam int SEL_W = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CONTROL_ONE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CONTROL_TWO = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COMPARE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_TICK_LOW = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_TICK_HIGH = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_SECONDS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_MINUTES = 8'h1c;

    // Field positions
    localparam int BIT_HOLD_REQ = 0;
    localparam int BIT_RUN = 1;
    localparam int POS_SEL = 2;
    localparam int BIT_PULSE_EN = 0;
    localparam int BIT_HOLD_ACK = 0;

    // Reset values and the seconds/minutes wrap limit
    localparam logic [CNT_W-1:0] RST_COMPARE = 20'h08000;
    localparam logic [SEL_W-1:0] RST_SEL = 3'h0;
    localparam logic [5:0] LAST_UNIT = 6'h3b;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

endpackage

// ===== tb/rtc_count_hold_and_pulse_out_bench.sv
// Self-checking bench for the RTC hold and pulse block
module rtc_count_hold_and_pulse_out_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_hold_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic rtc_src_clk = 1'b0;
    logic second_pulse_pin;
    axi_req_s req = '0;
    axi_rsp_s rsp;
    int bad_count = 0;
    int samples_checked = 0;
    int seed = 8;
    int c;
    int cnt;
    int secs;
    int s;
    logic pin_exp;
    logic [31:0] d;
    logic [1:0] r;

    rtc_count_hold_and_pulse_out DUT (
        .aclk(aclk),
        .aresetn(aresetn),
        .axi_req(req),
        .axi_rsp(rsp),
        .rtc_src_clk(rtc_src_clk),
        .second_pulse_pin(second_pulse_pin)
    );

    // 250 MHz clock
    initial
    begin
        forever #2 aclk = ~aclk;
    end

    task automatic stop_test();
    begin
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    task automatic check(input string w, input logic [31:0] e,
        input logic [31:0] g);
    begin
        samples_checked++;
        if (g !== e)
        begin
            $display("wrong value %s exp %h got %h", w, e, g);
            bad_count++;
        end
    end
    endtask

    // Write with both channels offered at once; waits for the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
    begin
        @(posedge aclk);
        req.awaddr <= a;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (rsp.awready)
                req.awvalid <= 1'b0;
            if (rsp.wready)
                req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        r = rsp.bresp;
        req.bready <= 1'b0;
    end
    endtask

    task automatic rd(input logic [7:0] a);
    begin
        @(posedge aclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (rsp.arready)
                req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
        input string w);
    begin
        rd(a);
        check(w, e, d);
    end
    endtask

    // One source edge, long enough to pass the synchroniser
    task automatic tick();
    begin
        rtc_src_clk <= 1'b1;
        repeat (8) @(posedge aclk);
        rtc_src_clk <= 1'b0;
        repeat (4) @(posedge aclk);
    end
    endtask

    // Expected counter, pin and seconds after one counted edge
    function automatic void step();
        if (cnt == c)
        begin
            cnt = 1;
            secs++;
        end
        else
            cnt++;
        if (cnt == c)
            pin_exp = 1'b0;
        if (cnt == c >> 1)
            pin_exp = 1'b1;
    endfunction

    // Watchdog, far beyond the few thousand cycles the run needs
    initial
    begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(OFF_COMPARE, RST_COMPARE, "compare");
        rd_chk(OFF_SECONDS, 0, "seconds");
        check("idle pin", 1, second_pulse_pin);
        rd(8'h40);
        check("bad read resp", RESP_SLVERR, r);
        check("bad read data", 0, d);
        wr(8'h44, $random(seed));
        check("bad write resp", RESP_SLVERR, r);
        // Prescale one halves the counted edges
        wr(OFF_CONTROL_ONE, 32'h6);
        rd(OFF_TICK_LOW);
        s = d;
        repeat (4) tick();
        rd_chk(OFF_TICK_LOW, s + 2, "scaled count");
        wr(OFF_CONTROL_ONE, 0);
        // Random compare, odd or even, output enabled before run
        c = 6 + ($random(seed) & 15);
        wr(OFF_COMPARE, c);
        wr(OFF_CONTROL_TWO, 1);
        wr(OFF_CONTROL_ONE, 2);
        cnt = 0;
        secs = 0;
        pin_exp = 1'b1;
        repeat (2 * c + 2)
        begin
            tick();
            step();
            check("pin", pin_exp, second_pulse_pin);
            rd_chk(OFF_TICK_LOW, cnt, "tick low");
            rd_chk(OFF_TICK_HIGH, 0, "tick high");
        end
        rd_chk(OFF_SECONDS, secs, "seconds");
        // Freeze, load seconds, miss two seconds, release
        wr(OFF_CONTROL_ONE, 3);
        do rd(OFF_STATUS); while (d[BIT_HOLD_ACK] !== 1'b1);
        s = $random(seed) & 31;
        wr(OFF_SECONDS, s);
        repeat (2 * c)
        begin
            tick();
            step();
        end
        rd_chk(OFF_SECONDS, s, "held seconds");
        wr(OFF_CONTROL_ONE, 2);
        rd_chk(OFF_SECONDS, s + 1, "released seconds");
        rd_chk(OFF_STATUS, 0, "ack");
        check("low pin", pin_exp, second_pulse_pin);
        // Seconds wrap carries into minutes; c ticks hold exactly one second
        s = $random(seed) & 31;
        wr(OFF_SECONDS, LAST_UNIT);
        wr(OFF_MINUTES, s);
        repeat (c)
        begin
            tick();
            step();
        end
        rd_chk(OFF_SECONDS, 0, "wrapped seconds");
        rd_chk(OFF_MINUTES, s + 1, "minutes");
        wr(OFF_CONTROL_ONE, 0);
        repeat (4) @(posedge aclk);
        check("stopped pin", 1, second_pulse_pin);
        stop_test();
    end
endmodule

// ===== tb/rtc_hold_monitor.sv
// Bus handshake and pulse pin checker for the RTC hold block
module rtc_hold_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rtc_hold_pkg::axi_req_s axi_req,
    input wire rtc_hold_pkg::axi_rsp_s axi_rsp,
    input wire logic rtc_src_clk,
    input wire logic second_pulse_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_hold_pkg::*;
    logic run_q;
    logic en_q;
    logic src_q;
    logic [3:0] since_q;
    logic wr_go;
    logic live;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    assign wr_go = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready;
    assign live = run_q && en_q;
    // Shadow of run and pulse enable; assumes both channels taken together
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_q <= 1'b0;
            en_q <= 1'b0;
        end
        else if (wr_go && axi_req.awaddr == OFF_CONTROL_ONE)
            run_q <= axi_req.wdata[BIT_RUN];
        else if (wr_go && axi_req.awaddr == OFF_CONTROL_TWO)
            en_q <= axi_req.wdata[BIT_PULSE_EN];
    end
    // Cycles since the source pin last moved, saturating
    always_ff @(posedge aclk)
    begin
        src_q <= rtc_src_clk;
        if (!aresetn || src_q != rtc_src_clk)
            since_q <= 4'h0;
        else if (since_q != 4'hf)
            since_q <= since_q + 4'h1;
    end
    // Both channels are held one edge after the take, answer one edge later
    chk_write_answer: assert property (wr_go |-> ##2 axi_rsp.bvalid)
        else $error("write answer late");
    chk_bvalid_kept: assert property ($fell(axi_rsp.bvalid)
        |-> $past(axi_req.bready)) else $error("write answer dropped");
    chk_aw_refused: assert property (axi_rsp.bvalid
        |-> !axi_rsp.awready && !axi_rsp.wready) else $error("aw taken");
    chk_read_answer: assert property (axi_req.arvalid &&
        axi_rsp.arready |=> axi_rsp.rvalid) else $error("read answer late");
    chk_rvalid_kept: assert property ($fell(axi_rsp.rvalid)
        |-> $past(axi_req.rready)) else $error("read answer dropped");
    chk_ar_refused: assert property (axi_rsp.rvalid |->
        !axi_rsp.arready) else $error("ar taken while busy");
    chk_pin_idle: assert property (!live [*3] |->
        second_pulse_pin) else $error("pin not high while stopped");
    chk_pin_fall: assert property ($fell(second_pulse_pin) |->
        live && since_q < 4'h8) else $error("pin fell without tick");
    chk_pin_rise: assert property ($rose(second_pulse_pin) && live
        |-> since_q < 4'h8) else $error("pin rose without tick");
    cover property (axi_rsp.bvalid && axi_req.bready);
    cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
    cover property ($fell(second_pulse_pin));
endmodule

bind rtc_count_hold_and_pulse_out rtc_hold_monitor mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .rtc_src_clk(rtc_src_clk),
    .second_pulse_pin(second_pulse_pin)
);
